// ---- hw/pdm_ctrl.v ----
/*
 * Power-down mode controller top: sleep and standby sequencing,
 * standby register initialisation pulses, wake handling, and the
 * APB-reached standby control register.
 * Assumes the CPU pulses sleep_req_i for one cycle on SLEEP, that
 * the clock tree honours clock_stop_o, and that the watchdog keeps
 * counting while wdog_clk_only_o is high.
 */
// Notes on behaviour
// - 8-bit control register, resets to 0x1f
// - Bit 7 picks sleep or standby
// - Setting bit 7 blocked while watchdog runs
// - Bit 6: hold or float ports
// - Setting bit 6 blocked while watchdog runs
// - Reserved: bit 5 zero, 4..0 ones
// - Sleep halts CPU, peripherals keep running
// - Accepted interrupt ends sleep
// - Masked or disabled interrupts do not wake
// - DMA address error ends sleep
// - Reset pin ends sleep
// - Standby stops CPU, clock, peripherals
// - Standby initialises DMA control registers
// - Standby initialises timers and converter
// - Standby initialises watchdog upper control
// - Standby initialises serial registers
// - Nonmaskable edge: watchdog clock, overflow wakes
// - Reset pin ends standby
`timescale 1ns/1ns
`include "pdm_defines.vh"

module pdm_ctrl #(
	parameter LVL_W  = `PDM_LVL_W,
	parameter INIT_W = `PDM_INIT_W
) (
	input  wire                    clock_i,
	input  wire                    rst_n_i,

	input  wire                    psel_i,
	input  wire                    penable_i,
	input  wire                    pwrite_i,
	input  wire [`PDM_ADDR_W-1:0]  paddr_i,
	input  wire [31:0]             pwdata_i,
	output wire [31:0]             prdata_o,
	output wire                    pready_o,
	output wire                    pslverr_o,

	input  wire                    sleep_req_i,
	input  wire                    irq_req_i,
	input  wire                    irq_src_en_i,
	input  wire [LVL_W-1:0]        irq_level_i,
	input  wire [LVL_W-1:0]        cpu_mask_level_i,
	input  wire                    dma_addr_err_i,
	input  wire                    nmi_i,
	input  wire                    nonmaskable_edge_select_i,
	input  wire                    watchdog_run_enable_i,
	input  wire                    watchdog_overflow_i,

	output reg                     cpu_halt_o,
	output reg                     clock_stop_o,
	output reg                     periph_stop_o,
	output reg                     wdog_clk_only_o,
	output reg                     port_float_o,
	output reg  [INIT_W-1:0]       periph_init_o,
	output reg                     wake_irq_o,
	output reg                     wake_addr_err_o,
	output reg                     wake_nmi_o,
	output reg  [`PDM_ST_W-1:0]    mode_o
);

	// ****************************************
	// States
	// ****************************************
	localparam [`PDM_ST_W-1:0] ST_RUN   = `PDM_ST_RUN;
	localparam [`PDM_ST_W-1:0] ST_SLEEP = `PDM_ST_SLEEP;
	localparam [`PDM_ST_W-1:0] ST_STBY  = `PDM_ST_STBY;
	localparam [`PDM_ST_W-1:0] ST_OSC   = `PDM_ST_OSC;

	reg  [`PDM_ST_W-1:0] state_r;
	reg  [`PDM_ST_W-1:0] state_nxt;
	reg  [INIT_W-1:0]    init_nxt;
	reg                  w_irq_nxt;
	reg                  w_aerr_nxt;
	reg                  w_nmi_nxt;
	reg                  float_nxt;

	wire                 deep_sel;
	wire                 float_sel;
	wire                 irq_ok;
	wire                 nmi_edge;

	// ****************************************
	// Register slave
	// ****************************************
	pdm_apb_regs u_regs (
		.clock_i             (clock_i),
		.rst_n_i             (rst_n_i),
		.psel_i              (psel_i),
		.penable_i           (penable_i),
		.pwrite_i            (pwrite_i),
		.paddr_i             (paddr_i),
		.pwdata_i            (pwdata_i),
		.wdog_run_i          (watchdog_run_enable_i),
		.state_i             (state_r),
		.prdata_o            (prdata_o),
		.pready_o            (pready_o),
		.pslverr_o           (pslverr_o),
		.deep_halt_select_o  (deep_sel),
		.port_float_select_o (float_sel)
	);

	// ****************************************
	// Wake sources
	// ****************************************
	pdm_wake_detect #(
		.LVL_W (LVL_W)
	) u_wake (
		.clock_i                   (clock_i),
		.rst_n_i                   (rst_n_i),
		.irq_req_i                 (irq_req_i),
		.irq_src_en_i              (irq_src_en_i),
		.irq_level_i               (irq_level_i),
		.cpu_mask_level_i          (cpu_mask_level_i),
		.nmi_i                     (nmi_i),
		.nonmaskable_edge_select_i (nonmaskable_edge_select_i),
		.irq_accept_o              (irq_ok),
		.nmi_edge_o                (nmi_edge)
	);

	// ****************************************
	// Next-state logic
	// ****************************************
	always @* begin
		state_nxt  = state_r;
		init_nxt   = {INIT_W{1'b0}};
		w_irq_nxt  = 1'b0;
		w_aerr_nxt = 1'b0;
		w_nmi_nxt  = 1'b0;
		float_nxt  = port_float_o;
		case (state_r)
			ST_RUN: begin
				if (sleep_req_i) begin
					if (deep_sel) begin
						state_nxt = ST_STBY;
						init_nxt[`PDM_INIT_DMA]  = 1'b1;
						init_nxt[`PDM_INIT_MTMR] = 1'b1;
						init_nxt[`PDM_INIT_ADC]  = 1'b1;
						init_nxt[`PDM_INIT_CTMR] = 1'b1;
						init_nxt[`PDM_INIT_WDOG] = 1'b1;
						init_nxt[`PDM_INIT_SER]  = 1'b1;
						float_nxt = float_sel;
					end else begin
						state_nxt = ST_SLEEP;
					end
				end
			end
			ST_SLEEP: begin
				if (dma_addr_err_i) begin
					state_nxt  = ST_RUN;
					w_aerr_nxt = 1'b1;
				end else if (irq_ok) begin
					state_nxt = ST_RUN;
					w_irq_nxt = 1'b1;
				end
			end
			ST_STBY: begin
				if (nmi_edge)
					state_nxt = ST_OSC;
			end
			ST_OSC: begin
				if (watchdog_overflow_i) begin
					state_nxt = ST_RUN;
					w_nmi_nxt = 1'b1;
					float_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt = ST_RUN;
				float_nxt = 1'b0;
			end
		endcase
	end

	// ****************************************
	// State decode
	// ****************************************
	// Standby and oscillator wait look the same to the clock tree,
	// so both stop outputs share one decode.
	function stop_state;
		input [`PDM_ST_W-1:0] st;
		begin
			stop_state = (st == ST_STBY) | (st == ST_OSC);
		end
	endfunction

	// ****************************************
	// State and level outputs
	// ****************************************
	// Outputs are decoded from the next state so that they move in
	// the same cycle as the state, with no extra cycle of lag.
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_r         <= ST_RUN;
			mode_o          <= ST_RUN;
			cpu_halt_o      <= 1'b0;
			clock_stop_o    <= 1'b0;
			periph_stop_o   <= 1'b0;
			wdog_clk_only_o <= 1'b0;
			port_float_o    <= 1'b0;
		end else begin
			state_r         <= state_nxt;
			mode_o          <= state_nxt;
			cpu_halt_o      <= (state_nxt != ST_RUN);
			clock_stop_o    <= stop_state(state_nxt);
			periph_stop_o   <= stop_state(state_nxt);
			wdog_clk_only_o <= (state_nxt == ST_OSC);
			port_float_o    <= float_nxt;
		end
	end

	// ****************************************
	// One-cycle pulse outputs
	// ****************************************
	// Reset clears the pulses too, so a reset that lands on a wake
	// never leaves a stale exception request for the CPU.
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			periph_init_o   <= {INIT_W{1'b0}};
			wake_irq_o      <= 1'b0;
			wake_addr_err_o <= 1'b0;
			wake_nmi_o      <= 1'b0;
		end else begin
			periph_init_o   <= init_nxt;
			wake_irq_o      <= w_irq_nxt;
			wake_addr_err_o <= w_aerr_nxt;
			wake_nmi_o      <= w_nmi_nxt;
		end
	end

endmodule // pdm_ctrl

// ---- hw/pdm_defines.vh ----
/*
 * Constants of the power-down mode controller: register offsets,
 * field positions, reset values, state codes and init vector layout.
 * Assumes inclusion by bare name from the hw/ folder.
 */
`ifndef PDM_DEFINES_VH
`define PDM_DEFINES_VH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define PDM_ADDR_W       12
`define PDM_OFF_CTRL     12'h000
`define PDM_OFF_STAT     12'h004

// ****************************************
// Standby control fields
// ****************************************
`define PDM_CTRL_RESET   8'h1f
`define PDM_BIT_DEEP     7
`define PDM_BIT_FLOAT    6
`define PDM_RSV_HI       1'b0
`define PDM_RSV_LO       5'h1f

// ****************************************
// Controller states (one-hot)
// ****************************************
`define PDM_ST_W         4
`define PDM_ST_RUN       4'h1
`define PDM_ST_SLEEP     4'h2
`define PDM_ST_STBY      4'h4
`define PDM_ST_OSC       4'h8

// ****************************************
// Standby init pulse vector
// ****************************************
`define PDM_INIT_W       6
`define PDM_INIT_DMA     0
`define PDM_INIT_MTMR    1
`define PDM_INIT_ADC     2
`define PDM_INIT_CTMR    3
`define PDM_INIT_WDOG    4
`define PDM_INIT_SER     5

`define PDM_LVL_W        4

`endif

// ---- hw/pdm_apb_regs.v ----
/*
 * APB slave holding the standby control register and a read-only
 * state register. Zero-wait: pready rises in the first access cycle.
 * Assumes an APB master and a synchronous active-low reset.
 */
`timescale 1ns/1ns
`include "pdm_defines.vh"

module pdm_apb_regs (
	input  wire                    clock_i,
	input  wire                    rst_n_i,
	input  wire                    psel_i,
	input  wire                    penable_i,
	input  wire                    pwrite_i,
	input  wire [`PDM_ADDR_W-1:0]  paddr_i,
	input  wire [31:0]             pwdata_i,
	input  wire                    wdog_run_i,
	input  wire [`PDM_ST_W-1:0]    state_i,
	output reg  [31:0]             prdata_o,
	output reg                     pready_o,
	output reg                     pslverr_o,
	output reg                     deep_halt_select_o,
	output reg                     port_float_select_o
);

	wire setup_w  = psel_i & ~penable_i;
	wire access_w = psel_i & penable_i & pready_o;
	wire hit_ctrl = (paddr_i == `PDM_OFF_CTRL);
	wire hit_stat = (paddr_i == `PDM_OFF_STAT);
	wire [7:0] ctrl_w;

	localparam [7:0] CTRL_RST = `PDM_CTRL_RESET;

	assign ctrl_w = {deep_halt_select_o, port_float_select_o,
		`PDM_RSV_HI, `PDM_RSV_LO};

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			prdata_o            <= 32'h0000_0000;
			pready_o            <= 1'b0;
			pslverr_o           <= 1'b0;
			deep_halt_select_o  <= CTRL_RST[`PDM_BIT_DEEP];
			port_float_select_o <= CTRL_RST[`PDM_BIT_FLOAT];
		end else if (setup_w) begin
			pready_o  <= 1'b1;
			pslverr_o <= ~(hit_ctrl | hit_stat);
			if (hit_ctrl)
				prdata_o <= {24'h00_0000, ctrl_w};
			else if (hit_stat)
				prdata_o <= {28'h000_0000, state_i};
			else
				prdata_o <= 32'h0000_0000;
		end else if (access_w) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			if (pwrite_i && hit_ctrl) begin
				if (!(wdog_run_i && pwdata_i[`PDM_BIT_DEEP]))
					deep_halt_select_o <= pwdata_i[`PDM_BIT_DEEP];
				if (!(wdog_run_i && pwdata_i[`PDM_BIT_FLOAT]))
					port_float_select_o <= pwdata_i[`PDM_BIT_FLOAT];
			end
		end else begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

endmodule // pdm_apb_regs

// ---- hw/pdm_wake_detect.v ----
/*
 * Wake source qualification: interrupt acceptance against the CPU
 * mask level and nonmaskable edge detection.
 * Assumes all inputs synchronous to clock_i.
 */
`timescale 1ns/1ns
`include "pdm_defines.vh"

module pdm_wake_detect #(
	parameter LVL_W = `PDM_LVL_W
) (
	input  wire             clock_i,
	input  wire             rst_n_i,
	input  wire             irq_req_i,
	input  wire             irq_src_en_i,
	input  wire [LVL_W-1:0] irq_level_i,
	input  wire [LVL_W-1:0] cpu_mask_level_i,
	input  wire             nmi_i,
	input  wire             nonmaskable_edge_select_i,
	output wire             irq_accept_o,
	output wire             nmi_edge_o
);

	reg nmi_prev_r;

	assign irq_accept_o = irq_req_i & irq_src_en_i &
		(irq_level_i > cpu_mask_level_i);

	// Select 1 means rising edge, 0 falling edge
	assign nmi_edge_o = nonmaskable_edge_select_i ? (nmi_i & ~nmi_prev_r)
		: (~nmi_i & nmi_prev_r);

	always @(posedge clock_i) begin
		if (!rst_n_i)
			nmi_prev_r <= 1'b0;
		else
			nmi_prev_r <= nmi_i;
	end

endmodule // pdm_wake_detect

// ---- tb/pdm_ctrl_chk.sv ----
/* Concurrent checks on the ports of pdm_ctrl.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ns
`include "pdm_defines.vh"
module pdm_ctrl_chk #(
	parameter LVL_W  = 4,
	parameter INIT_W = 6
) (
	input wire              clock_i,
	input wire              rst_n_i,
	input wire              psel_i,
	input wire              penable_i,
	input wire              sleep_req_i,
	input wire              irq_req_i,
	input wire              irq_src_en_i,
	input wire [LVL_W-1:0]  irq_level_i,
	input wire [LVL_W-1:0]  cpu_mask_level_i,
	input wire              dma_addr_err_i,
	input wire              watchdog_overflow_i,
	input wire              pready_o,
	input wire              cpu_halt_o,
	input wire              clock_stop_o,
	input wire              periph_stop_o,
	input wire              port_float_o,
	input wire [INIT_W-1:0] periph_init_o,
	input wire              wake_irq_o,
	input wire              wake_addr_err_o,
	input wire              wake_nmi_o,
	input wire [3:0]        mode_o
);
	// ****************************************
	// APB, mode and wake checks
	// ****************************************
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	wire good = irq_req_i && irq_src_en_i && (irq_level_i > cpu_mask_level_i);

	a_apb_zero_wait: assert property (psel_i && !penable_i |=> pready_o)
		else $error("pready missing after setup");
	a_sleep_halt: assert property (mode_o == 4'h1 && sleep_req_i |=> cpu_halt_o && mode_o != 4'h1)
		else $error("sleep request not taken");
	a_sleep_runs: assert property (mode_o == 4'h2 |-> !clock_stop_o && !periph_stop_o)
		else $error("peripherals stopped in sleep");
	a_stby_stop: assert property (mode_o == 4'h4 |-> cpu_halt_o && clock_stop_o && periph_stop_o)
		else $error("standby not stopping all");
	a_init_once: assert property (periph_init_o != 0 |-> periph_init_o == 6'h3f && mode_o == 4'h4 ##1 periph_init_o == 0)
		else $error("init pulse wrong");
	a_irq_wake: assert property (mode_o == 4'h2 && good && !dma_addr_err_i |=> wake_irq_o && mode_o == 4'h1)
		else $error("accepted irq did not wake");
	a_irq_masked: assert property (mode_o == 4'h2 && !good && !dma_addr_err_i |=> !wake_irq_o && mode_o == 4'h2)
		else $error("masked irq woke");
	a_aerr_wake: assert property (mode_o == 4'h2 && dma_addr_err_i |=> wake_addr_err_o && !wake_irq_o && mode_o == 4'h1)
		else $error("address error did not wake");
	a_osc_wake: assert property (mode_o == 4'h8 && watchdog_overflow_i |=> wake_nmi_o && mode_o == 4'h1 && !port_float_o && !clock_stop_o)
		else $error("overflow did not end standby");
	a_wake_runs: assert property (wake_irq_o || wake_addr_err_o || wake_nmi_o |->
		!cpu_halt_o && mode_o == 4'h1)
		else $error("CPU still halted after wake");
endmodule // pdm_ctrl_chk

bind pdm_ctrl pdm_ctrl_chk #(.LVL_W(LVL_W), .INIT_W(INIT_W)) u_pdm_ctrl_chk (
	.clock_i, .rst_n_i, .psel_i, .penable_i, .sleep_req_i, .irq_req_i, .irq_src_en_i,
	.irq_level_i, .cpu_mask_level_i, .dma_addr_err_i, .watchdog_overflow_i, .pready_o,
	.cpu_halt_o, .clock_stop_o, .periph_stop_o, .port_float_o, .periph_init_o,
	.wake_irq_o, .wake_addr_err_o, .wake_nmi_o, .mode_o);

// ---- tb/pdm_wdog_model.sv ----
/* Watchdog side model: counts while only the watchdog is clocked,
   then flags overflow. Assumes the controller's clock and reset. */
`timescale 1ns/1ns
module pdm_wdog_model #(
	parameter [7:0] SETTLE = 8'h08
) (
	input  wire clock_i,
	input  wire rst_n_i,
	input  wire wdog_clk_only_i,
	output reg  overflow_o
);
	reg [7:0] cnt_r;
	always @(posedge clock_i) begin
		if (!rst_n_i || !wdog_clk_only_i) begin
			cnt_r <= 8'h00;
			overflow_o <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 8'h01;
			overflow_o <= (cnt_r == SETTLE);
		end
	end
endmodule // pdm_wdog_model

// ---- tb/tb_pdm_ctrl.sv ----
/* Self-checking bench for pdm_ctrl with a watchdog model.
   Assumes a 100 MHz clock and zero-wait APB answers. */
`timescale 1ns/1ns
`include "pdm_defines.vh"
module tb_pdm_ctrl;
	reg         clock_i = 1'b0;
	reg         rst_n_i = 1'b0;
	reg         psel, pen, pwr, slp, irq, ien, aerr, nmi, nsel, wrun, err;
	reg  [11:0] padr;
	reg  [31:0] pwd, rs;
	reg  [3:0]  lvl, msk;
	wire [31:0] prd;
	wire [5:0]  init;
	wire [3:0]  mode;
	wire        rdy, serr, halt, cst, pst, wonly, pflt, wirq, waer, wnmi, ovf;
	integer     miscompares = 0, n_compared = 0, cyc = 0, i, k;
	reg  [31:0] exq [$];

	pdm_ctrl u_pdm_ctrl (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
		.pslverr_o(serr), .sleep_req_i(slp), .irq_req_i(irq), .irq_src_en_i(ien),
		.irq_level_i(lvl), .cpu_mask_level_i(msk), .dma_addr_err_i(aerr), .nmi_i(nmi),
		.nonmaskable_edge_select_i(nsel), .watchdog_run_enable_i(wrun),
		.watchdog_overflow_i(ovf), .cpu_halt_o(halt), .clock_stop_o(cst),
		.periph_stop_o(pst), .wdog_clk_only_o(wonly), .port_float_o(pflt),
		.periph_init_o(init), .wake_irq_o(wirq), .wake_addr_err_o(waer),
		.wake_nmi_o(wnmi), .mode_o(mode));
	pdm_wdog_model #(.SETTLE(8'h08)) u_pdm_wdog_model (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .wdog_clk_only_i(wonly), .overflow_o(ovf));

	initial forever #5 clock_i = ~clock_i;

	function [31:0] xs(input [31:0] v);
		reg [31:0] t;
		begin
			t = v ^ (v << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task check(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task end_of_test;
		begin
			$display("compared %0d mismatched %0d", n_compared, miscompares);
			if (miscompares == 0 && n_compared > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task step(input integer n);
		repeat (n) @(posedge clock_i);
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge clock_i);
			{psel, pen, pwr, padr, pwd} <= {2'b10, w, a, d};
			@(posedge clock_i);
			pen <= 1'b1;
			do begin
				@(posedge clock_i);
				err = serr;
			end while (rdy !== 1'b1);
			{psel, pen} <= 2'b00;
		end
	endtask
	task rd(input [11:0] a, input [31:0] e);
		begin
			exq.push_back(e);
			apb(1'b0, a, 32'h0);
		end
	endtask
	// Pulse the SLEEP request, return once the new mode is visible
	task sleep;
		begin
			@(posedge clock_i);
			slp <= 1'b1;
			@(posedge clock_i);
			slp <= 1'b0;
			@(posedge clock_i);
		end
	endtask

	// ****************************************
	// Read monitor and hang guard
	// ****************************************
	always @(posedge clock_i) begin
		cyc = cyc + 1;
		if (cyc > 3000) begin
			miscompares = miscompares + 1;
			end_of_test;
		end
		if (rdy === 1'b1 && pen && !pwr)
			check(prd, exq.pop_front());
	end

	initial begin
		{psel, pen, pwr, slp, irq, ien, aerr, nmi, wrun} = 9'h000;
		{padr, pwd, lvl, msk, rs, nsel} = {44'h0, 8'h00, 32'h29, 1'b1};
		repeat (20) @(posedge clock_i);
		rst_n_i <= 1'b1;
		rd(12'h000, 32'h1f);
		wrun <= 1'b1;
		apb(1'b1, 12'h000, 32'hc0); // reserved bits written 0
		rd(12'h000, 32'h1f);
		wrun <= 1'b0;
		apb(1'b1, 12'h000, 32'hc0); // reserved bits written 0
		rd(12'h000, 32'hdf);
		wrun <= 1'b1;
		apb(1'b1, 12'h000, 32'h00);
		rd(12'h000, 32'h1f);
		rd(12'h004, 32'h1);
		rd(12'h008, 32'h0);
		check(err, 1'b1);
		$display("register test done");
		for (i = 0; i < 3; i = i + 1) begin
			sleep;
			rs = xs(rs);
			{irq, ien, msk, lvl} <= {2'b11, 1'b0, rs[2:0], 1'b0, rs[2:0]};
			step(3);
			check({halt, cst, pst, mode}, {3'b100, `PDM_ST_SLEEP});
			{ien, lvl} <= {1'b0, 4'h8 | rs[6:4]};
			step(3);
			check(mode, `PDM_ST_SLEEP);
			ien <= 1'b1;
			step(2);
			check({wirq, halt, mode}, {2'b10, `PDM_ST_RUN});
			irq <= 1'b0;
		end
		sleep;
		{irq, ien, aerr, lvl, msk} <= {3'b111, 8'hf0};
		step(2);
		check({waer, wirq, mode}, {2'b10, `PDM_ST_RUN});
		{irq, aerr} <= 2'b00;
		sleep;
		rst_n_i <= 1'b0;
		step(2);
		rst_n_i <= 1'b1;
		check(mode, `PDM_ST_RUN);
		$display("sleep test done");
		wrun <= 1'b0;
		apb(1'b1, 12'h000, 32'hc0);
		// Falling-edge select: pin idles high on entry
		{nmi, nsel} <= 2'b10;
		sleep;
		check({halt, cst, pst, pflt, init, mode}, {4'hf, 6'h3f, `PDM_ST_STBY});
		{irq, ien, aerr, lvl, msk} <= {3'b111, 8'hf0};
		step(3);
		check({wirq, waer, mode}, {2'b00, `PDM_ST_STBY});
		{irq, aerr} <= 2'b00;
		nmi <= 1'b0;
		step(2);
		check({wonly, mode}, {1'b1, `PDM_ST_OSC});
		k = 0;
		while (wnmi !== 1'b1 && k < 20) begin
			step(1);
			k = k + 1;
		end
		check({wnmi, pflt, cst, mode}, {3'b100, `PDM_ST_RUN});
		// Rising-edge select, ports held in standby
		{nmi, nsel} <= 2'b01;
		apb(1'b1, 12'h000, 32'h80);
		sleep;
		check({pflt, halt, mode}, {2'b01, `PDM_ST_STBY});
		nmi <= 1'b1;
		step(2);
		check({wonly, mode}, {1'b1, `PDM_ST_OSC});
		rst_n_i <= 1'b0;
		step(2);
		rst_n_i <= 1'b1;
		check({wonly, halt, mode}, {2'b00, `PDM_ST_RUN});
		rd(12'h000, 32'h1f);
		$display("standby test done");
		end_of_test;
	end
endmodule // tb_pdm_ctrl
